// >>> design/host_sync.sv
// Two-flop synchroniser for asynchronous host pins.
`timescale 1ns/1ps
`default_nettype none
module host_sync
  import sysctl_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk, // Core clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes the flops while low.
  input wire logic [WIDTH-1:0] din, // Asynchronous inputs.
  output logic [WIDTH-1:0] dout // Synchronised outputs.
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else if (clk_en)
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> design/sysctl_decoder.sv
// System-control command decoder: init, standby and display on/off commands.
// Function
// - Standby after power-up and standby command.
// - Init command byte leaves standby immediately.
// - Normal mode after init plus eight parameters.
// - Code 40h is init; parameters fill 00h-07h.
// - First parameter bit fields for register 00h.
// - Second parameter: bit 7 and bits 3-0.
// - Code 53h is standby, no parameters.
// - Code 58h is display-off, one parameter.
// - Select high is command, low is parameter.
// - Init command takes exactly eight parameters.
// - Display on/off codes 59h/58h, one parameter.
`timescale 1ns/1ps
`default_nettype none
module sysctl_decoder
  import sysctl_pkg::*;
(
  input wire logic ref_clk, // Core clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic cmd_data_select, // Host pin: 1 command, 0 parameter.
  input wire logic wr_n, // Host write strobe pin, active low.
  input wire logic [7:0] host_data, // Host data pins.
  output logic standby, // High while in low-power standby.
  output logic normal_mode, // High once init has completed.
  output logic display_enable, // Display switched on by on command.
  output logic [7:0] cfg_reg [NUM_CFG], // Configuration registers 00h-07h.
  output logic [7:0] display_attribute_ctrl, // Register 0Ah.
  output logic [3:0] param_count // Parameters taken so far.
);
  logic [9:0] pins_sync;
  logic sel_s;
  logic wr_act_s;
  logic [7:0] data_s;
  logic wr_act_d_r;
  logic wr_pulse;
  logic cmd_wr;
  logic par_wr;
  seq_state_t state_r;
  logic [3:0] cnt_r;
  logic disp_on_pend_r;
  logic init_cmd;
  logic standby_cmd;
  logic init_last;
  logic standby_r;
  logic normal_mode_r;
  logic display_enable_r;
  logic [7:0] attr_r;
  logic [7:0] cfg_r [NUM_CFG];

  // The host bus is asynchronous, so every pin is synchronised first.
  // The strobe enters inverted: the flops reset to zero, which then equals
  // the idle level, so no false write edge follows the release of reset.
  host_sync #(.WIDTH(10)) u_sync
  (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .din({cmd_data_select, ~wr_n, host_data}),
    .dout(pins_sync)
  );

  // Unpack the synchronised pins; all ten bits share the same two stages.
  assign sel_s = pins_sync[9];
  assign wr_act_s = pins_sync[8];
  assign data_s = pins_sync[7:0];

  // Data settles before the strobe ends, so the end of the write is sampled.
  // The delayed copy resets to the idle level for the same reason as above.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wr_act_d_r <= 1'b0;
    else if (clk_en)
      wr_act_d_r <= wr_act_s;
  end

  // A write is taken when the synchronised active strobe drops.
  // The host holds data and select past that point, so they are still
  // valid in the cycle in which the pulse is decoded.
  assign wr_pulse = clk_en && wr_act_d_r && !wr_act_s;
  assign cmd_wr = wr_pulse && sel_s;
  assign par_wr = wr_pulse && !sel_s;

  // Shared decodes of the mode-changing writes.
  assign init_cmd = cmd_wr && (data_s == CMD_INIT);
  assign standby_cmd = cmd_wr && (data_s == CMD_STANDBY);
  assign init_last = par_wr && (state_r == SEQ_INIT)
                     && (cnt_r == INIT_PARAMS - 4'h1);

  // Returns the byte stored for an init parameter at a given index.
  // Reserved bits are forced here so a careless host cannot set them.
  function automatic logic [7:0] init_field(input logic [3:0] idx,
                                            input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (idx == 4'h0)
      v = (d & CFG0_MASK) | CFG0_FIXED;
    else if (idx == 4'h1)
      v = d & CFG1_MASK;
    else if (idx == 4'h2)
      v = d & 8'h0f;
    else if (idx == 4'h7)
      v = d & 8'h7f;
    return v;
  endfunction

  // Sequence state: which command owns the incoming parameters.
  // A command byte always wins over any open sequence: the counter and
  // the state restart, so a half-written sequence is simply abandoned
  // and its remaining bytes can never land in the wrong registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= SEQ_IDLE;
      cnt_r <= 4'h0;
      disp_on_pend_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      cnt_r <= 4'h0;
      disp_on_pend_r <= (data_s == CMD_DISP_ON);
      case (data_s)
        CMD_INIT: state_r <= SEQ_INIT;
        CMD_DISPLAY_OFF_COMMAND: state_r <= SEQ_DISP;
        CMD_DISP_ON: state_r <= SEQ_DISP;
        default: state_r <= SEQ_IDLE;
      endcase
    end
    else if (par_wr)
    begin
      case (state_r)
        SEQ_INIT:
        begin
          if (cnt_r == INIT_PARAMS - 4'h1)
            state_r <= SEQ_IDLE;
          cnt_r <= cnt_r + 4'h1;
        end
        SEQ_DISP:
        begin
          state_r <= SEQ_IDLE;
          cnt_r <= DISP_PARAMS;
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  // Init parameters land in order in registers 00h-07h.
  // Each slot compares the counter with its own index, so a byte that
  // arrives after the eighth finds no slot and is dropped.
  generate
    for (genvar i = 0; i < NUM_CFG; i++)
    begin : g_cfg
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          cfg_r[i] <= REG_RESET;
        else if (par_wr && state_r == SEQ_INIT && cnt_r == 4'(i))
          cfg_r[i] <= init_field(4'(i), data_s);
      end
    end
  endgenerate

  // The single display parameter holds all eight attribute bits.
  // The on/off choice was latched with the command byte, so the on and
  // off commands share one parameter path.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      attr_r <= REG_RESET;
      display_enable_r <= 1'b0;
    end
    else if (par_wr && state_r == SEQ_DISP)
    begin
      attr_r <= data_s;
      display_enable_r <= disp_on_pend_r;
    end
  end

  // Power mode: standby at reset, left on init byte, entered on standby.
  // Init and standby bytes are distinct codes, so at most one branch of
  // the chain fires in a cycle and no set and clear can race.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      standby_r <= 1'b1;
      normal_mode_r <= 1'b0;
    end
    else if (init_cmd)
    begin
      standby_r <= 1'b0;
      normal_mode_r <= 1'b0;
    end
    else if (standby_cmd)
    begin
      standby_r <= 1'b1;
      normal_mode_r <= 1'b0;
    end
    else if (init_last)
      normal_mode_r <= 1'b1;
  end

  // Every visible output is a flop; these only carry them onto the ports.
  assign standby = standby_r;
  assign normal_mode = normal_mode_r;
  assign display_enable = display_enable_r;
  assign display_attribute_ctrl = attr_r;
  assign cfg_reg = cfg_r;

  // No clock-ready gate exists here; the host owns the crystal wait.
  // A gate would need the oscillator's settle time, which only the board
  // knows, so the counter is exposed for the host to pace itself.
  assign param_count = cnt_r;
endmodule
`default_nettype wire

// >>> design/sysctl_pkg.sv
// Package of constants for the system-control command decoder.
package sysctl_pkg;
  // Command byte codes.
  localparam logic [7:0] CMD_INIT = 8'h40;
  localparam logic [7:0] CMD_STANDBY = 8'h53;
  localparam logic [7:0] CMD_DISPLAY_OFF_COMMAND = 8'h58;
  localparam logic [7:0] CMD_DISP_ON = 8'h59;
  // Parameter counts per command.
  localparam logic [3:0] INIT_PARAMS = 4'h8;
  localparam logic [3:0] DISP_PARAMS = 4'h1;
  // Register offsets.
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_CFG1 = 4'h1;
  localparam logic [3:0] REG_ATTR = 4'ha;
  localparam int NUM_CFG = 8;
  // Field positions in configuration register zero.
  localparam int SCREEN_ORIGIN_COMP_BIT = 5;
  localparam int FIXED_ONE_BIT = 4;
  localparam int PANEL_DRIVE_BIT = 3;
  localparam int CHAR_HEIGHT_SELECT_BIT = 2;
  localparam int CHAR_GEN_SELECT_BIT = 0;
  // Field mask of the stored first and second parameter.
  localparam logic [7:0] CFG0_MASK = 8'h2d;
  localparam logic [7:0] CFG0_FIXED = 8'h10;
  localparam logic [7:0] CFG1_MASK = 8'h8f;
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Parameter-sequence states.
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_DISP = 2'b10
  } seq_state_t;
endpackage

// >>> tb/sysctl_decoder_monitor.sv
// Checker of the command decoder's port behaviour.
`timescale 1ns/1ps
`default_nettype none
module sysctl_decoder_monitor
  import sysctl_pkg::*;
(
  input wire logic ref_clk, // Core clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic wr_n, // Host write strobe.
  input wire logic standby, // Standby flag.
  input wire logic normal_mode, // Normal mode flag.
  input wire logic [7:0] cfg_reg [NUM_CFG], // Configuration registers.
  input wire logic [7:0] display_attribute_ctrl, // Attribute register.
  input wire logic [3:0] param_count // Parameter counter.
);
  logic [3:0] since_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Cycles since the last strobe rise; saturates so stale writes cannot match.
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) since_r <= 4'hf;
    else if ($rose(wr_n)) since_r <= 4'h0;
    else if (since_r != 4'hf) since_r <= since_r + 4'h1;
  // Port-level rules; each label carries the rule that it watches.
  property p_lat; $changed(param_count) |-> since_r inside {[1:5]}; endproperty
  a_lat: assert property (p_lat)
    else $error("counter moved without write");
  property p_mode; normal_mode |-> !standby; endproperty
  a_mode: assert property (p_mode)
    else $error("normal during standby");
  property p_max; param_count <= 4'h8; endproperty
  a_max: assert property (p_max)
    else $error("counter past eight");
  property p_cfg0;
    $changed(cfg_reg[0]) |-> (cfg_reg[0] & 8'hd2) == 8'h10;
  endproperty
  a_cfg0: assert property (p_cfg0)
    else $error("bad fixed bits in 00h");
  property p_cfg1;
    $changed(cfg_reg[1]) |-> cfg_reg[1][6:4] == 3'h0;
  endproperty
  a_cfg1: assert property (p_cfg1)
    else $error("bad bits in 01h");
  property p_cfg7; $changed(cfg_reg[7]) |-> !cfg_reg[7][7]; endproperty
  a_cfg7: assert property (p_cfg7)
    else $error("bit 7 of 07h set");
  property p_done; $rose(normal_mode) |-> param_count == 4'h8; endproperty
  a_done: assert property (p_done)
    else $error("normal before eighth");
  property p_wake; $fell(standby) |-> param_count == 4'h0; endproperty
  a_wake: assert property (p_wake)
    else $error("wake not on command");
  property p_sleep; $rose(standby) |-> !normal_mode; endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby kept normal");
  property p_attr;
    $changed(display_attribute_ctrl) |-> param_count == 4'h1;
  endproperty
  a_attr: assert property (p_attr)
    else $error("attr not first param");
  c_norm: cover property ($rose(normal_mode));
  c_sleep: cover property ($rose(standby));
  c_attr: cover property ($changed(display_attribute_ctrl));
endmodule
bind sysctl_decoder sysctl_decoder_monitor u_sysctl_decoder_monitor (
  .ref_clk(ref_clk), .arst_n(arst_n), .wr_n(wr_n), .standby(standby),
  .normal_mode(normal_mode), .cfg_reg(cfg_reg),
  .display_attribute_ctrl(display_attribute_ctrl), .param_count(param_count));
`default_nettype wire

// >>> tb/sysctl_host.sv
// Host processor model that writes command and parameter bytes.
`timescale 1ns/1ps
`default_nettype none
module sysctl_host
  import sysctl_pkg::*;
#(
  parameter int XTAL_WAIT = 4
)
(
  input wire logic ref_clk, // Core clock.
  output logic sel, // Command or parameter select.
  output logic wr_n, // Write strobe, active low.
  output logic [7:0] data // Data bus.
);
  initial
  begin
    sel = 1'b0;
    wr_n = 1'b1;
    data = 8'h00;
  end
  // One write; the bus is scrambled after hold so stale values cannot help.
  task put(input logic s, input logic [7:0] d);
    @(posedge ref_clk) #1;
    sel = s;
    data = d;
    wr_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 wr_n = 1'b1;
    if (s && d == CMD_INIT) repeat (XTAL_WAIT) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    #1 data = ~d;
    sel = ~s;
  endtask
endmodule
`default_nettype wire

// >>> tb/system_control_command_decoder_bench.sv
// Self-checking bench of the system-control command decoder.
`timescale 1ns/1ps
`default_nettype none
module system_control_command_decoder_bench;
  import sysctl_pkg::*;
  logic ref_clk, arst_n, sel, wr_n, standby, normal_mode, display_enable;
  logic [7:0] host_data, display_attribute_ctrl;
  logic [7:0] cfg_reg [NUM_CFG];
  logic [3:0] param_count;
  logic clk_en;
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] rows [3][3] = '{'{CMD_DISP_ON, 8'h3c, 8'h01},
    '{CMD_DISPLAY_OFF_COMMAND, 8'hc3, 8'h00}, '{CMD_DISP_ON, 8'hff, 8'h01}};
  logic [7:0] exp_cfg [8] = '{8'h3d, 8'h8f, 8'h0f, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h7f};
  sysctl_host u_sysctl_host (.ref_clk(ref_clk), .sel(sel), .wr_n(wr_n),
    .data(host_data));
  sysctl_decoder u_sysctl_decoder (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(clk_en), .cmd_data_select(sel), .wr_n(wr_n),
    .host_data(host_data),
    .standby(standby), .normal_mode(normal_mode),
    .display_enable(display_enable), .cfg_reg(cfg_reg),
    .display_attribute_ctrl(display_attribute_ctrl),
    .param_count(param_count));
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Free-running clock at 200 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // A hang counts as a failure.
  initial
  begin
    #20us;
    err_total++;
    test_done();
  end
  // Main sequence: reset, table of display commands, then edge cases.
  initial
  begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    chk(standby, 8'h01);
    chk(param_count, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 3; i++)
    begin
      u_sysctl_host.put(1'b1, rows[i][0]);
      u_sysctl_host.put(1'b0, rows[i][1]);
      chk(display_attribute_ctrl, rows[i][1]);
      chk(display_enable, rows[i][2]);
    end
    $display("display table done");
    u_sysctl_host.put(1'b1, CMD_INIT);
    chk(standby, 8'h00);
    // The host keeps the fixed bits of the first parameter as required.
    for (int i = 0; i < 8; i++)
      u_sysctl_host.put(1'b0, (i == 0) ? 8'h3d : 8'hff);
    chk(normal_mode, 8'h01);
    for (int i = 0; i < 8; i++)
      chk(cfg_reg[i], exp_cfg[i]);
    u_sysctl_host.put(1'b0, 8'h00);
    chk(cfg_reg[0], 8'h3d);
    u_sysctl_host.put(1'b1, CMD_STANDBY);
    chk(standby, 8'h01);
    chk(normal_mode, 8'h00);
    u_sysctl_host.put(1'b0, 8'h55);
    chk(display_attribute_ctrl, 8'hff);
    u_sysctl_host.put(1'b1, CMD_INIT);
    u_sysctl_host.put(1'b0, 8'h10);
    u_sysctl_host.put(1'b1, CMD_DISPLAY_OFF_COMMAND);
    u_sysctl_host.put(1'b0, 8'h11);
    u_sysctl_host.put(1'b0, 8'h22);
    chk(cfg_reg[0], 8'h10);
    chk(cfg_reg[1], 8'h8f);
    chk(display_attribute_ctrl, 8'h11);
    chk(normal_mode, 8'h00);
    $display("edge cases done");
    // A write made while the enable is low must leave all state untouched.
    clk_en = 1'b0;
    u_sysctl_host.put(1'b1, CMD_STANDBY);
    chk(standby, 8'h00);
    chk(param_count, 8'h01);
    clk_en = 1'b1;
    u_sysctl_host.put(1'b1, CMD_STANDBY);
    chk(standby, 8'h01);
    chk(param_count, 8'h00);
    $display("freeze test done");
    test_done();
  end
endmodule
`default_nettype wire
